// *** codec_irq_defines.svh ***
/*
  Offsets, field positions, reset values and widths of the host
  interrupt and status block of the video codec.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CODEC_IRQ_DEFINES_SVH
`define CODEC_IRQ_DEFINES_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OFF_MODE 8'h00
`define OFF_MASK 8'h04
`define OFF_STATUS 8'h08

// ****************************************************************
// mode control fields
// ****************************************************************
`define MODE_W 3
`define MODE_IRQ_HIGH 0
`define MODE_DECODE 1
`define MODE_SOFT_RUN 2
`define MODE_RESET 3'h1

// ****************************************************************
// status and mask fields
// ****************************************************************
`define SRC_W 6
`define SRC_FIFO_STOP 0
`define SRC_FIFO_SERVICE 1
`define SRC_FIFO_ERROR 2
`define SRC_LAST_WORD 3
`define SRC_STATS_READY 4
`define SRC_CCIR_ERROR 5
`define MASK_RESET 6'h00

`endif

// *** codec_irq_pkg.sv ***
/*
  Types shared by the host interrupt and status block.
  Assumes the defines header sits in the same folder.
*/
`include "codec_irq_defines.svh"

package codec_irq_pkg;

  typedef logic [`SRC_W-1:0] src_vec_t;
  typedef logic [`MODE_W-1:0] mode_vec_t;

  typedef struct packed {
    logic flag;
  } flag_state_t;

  typedef struct packed {
    logic irq;
  } gate_state_t;

  typedef struct packed {
    mode_vec_t mode;
    src_vec_t mask;
    src_vec_t shown;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_word;
    logic service;
  } top_state_t;

endpackage : codec_irq_pkg

// *** sticky_flag.sv ***
/*
  One sticky event flag: a set pulse raises it, a clear pulse drops it.
  Assumes set and clear are synchronous single-cycle requests on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  codec_irq_pkg::flag_state_t state;
  codec_irq_pkg::flag_state_t next_state;

  always_comb begin
    next_state = state;
    // set beats clear so an event in the clearing cycle survives
    if (set) begin
      next_state.flag = 1'b1;
    end else if (clear) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule : sticky_flag

`default_nettype wire

// *** irq_gate.sv ***
/*
  Masks the status sources onto one registered interrupt line of
  programmable polarity.
  Assumes status, mask and polarity are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "codec_irq_defines.svh"

module irq_gate (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`SRC_W-1:0] status,
  input wire logic [`SRC_W-1:0] mask,
  input wire logic active_high,
  output logic irq
);

  codec_irq_pkg::gate_state_t state;
  codec_irq_pkg::gate_state_t next_state;
  logic pending;

  always_comb begin
    next_state = state;
    pending = |(status & mask);
    // polarity select, idle level when nothing pending
    next_state.irq = active_high ? pending : ~pending;
  end

  always_ff @(posedge clk) begin
    // reset state; the default mode is active high so the line is low
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign irq = state.irq;

endmodule : irq_gate

`default_nettype wire

// *** codec_host_interrupt_status.sv ***
/*
  Host event signalling of the video codec: statistics ready, last
  compressed word, fifo service request, sticky error flags and one
  maskable host interrupt, with mode, mask and status over APB.
  Assumes one clock, a synchronous active-low reset, and event inputs
  that are single-cycle pulses synchronous to clk.
*/
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "codec_irq_defines.svh"

module codec_host_interrupt_status (
  input wire logic clk,
  input wire logic reset_n,
  // ****************************************************************
  // apb slave
  // ****************************************************************
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ****************************************************************
  // codec core events and levels
  // ****************************************************************
  input wire logic stats_refreshed,
  input wire logic last_word_ready,
  input wire logic last_word_taken,
  input wire logic fifo_nearly_full,
  input wire logic fifo_nearly_empty,
  input wire logic fifo_stop_event,
  input wire logic fifo_error_event,
  input wire logic ccir_error_event,
  // ****************************************************************
  // pins
  // ****************************************************************
  output logic stats_ready_out,
  output logic last_word_flag,
  output logic fifo_service_request,
  output logic host_irq_out,
  output logic decode_mode,
  output logic soft_reset_bit
);

  codec_irq_pkg::top_state_t state;
  codec_irq_pkg::top_state_t next_state;

  codec_irq_pkg::src_vec_t status;
  codec_irq_pkg::src_vec_t read_clear;
  logic setup;
  logic done;
  logic hit_mode;
  logic hit_mask;
  logic hit_status;
  logic fifo_stop_flag;
  logic fifo_error_flag;
  logic ccir_error_flag;
  logic stats_ready_source;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign setup = psel && !penable;
  assign done = psel && penable && state.pready;
  assign hit_mode = (paddr == `OFF_MODE);
  assign hit_mask = (paddr == `OFF_MASK);
  assign hit_status = (paddr == `OFF_STATUS);

  // only bits already shown to software are cleared by the read,
  // so an event landing between setup and access is kept
  always_comb begin
    read_clear = '0;
    if (done && !pwrite && hit_status) begin
      read_clear = state.shown;
    end
  end

  // ****************************************************************
  // sticky event sources
  // ****************************************************************
  sticky_flag u_fifo_stop (
    .clk(clk),
    .reset_n(reset_n),
    .set(fifo_stop_event),
    .clear(read_clear[`SRC_FIFO_STOP]),
    .flag(fifo_stop_flag)
  );

  sticky_flag u_fifo_error (
    .clk(clk),
    .reset_n(reset_n),
    .set(fifo_error_event),
    .clear(read_clear[`SRC_FIFO_ERROR]),
    .flag(fifo_error_flag)
  );

  sticky_flag u_ccir_error (
    .clk(clk),
    .reset_n(reset_n),
    .set(ccir_error_event),
    .clear(read_clear[`SRC_CCIR_ERROR]),
    .flag(ccir_error_flag)
  );

  // raised by the once-per-field refresh, held until read
  sticky_flag u_stats_ready (
    .clk(clk),
    .reset_n(reset_n),
    .set(stats_refreshed),
    .clear(read_clear[`SRC_STATS_READY]),
    .flag(stats_ready_source)
  );

  // ****************************************************************
  // status word
  // ****************************************************************
  always_comb begin
    status = '0;
    status[`SRC_FIFO_STOP] = fifo_stop_flag;
    status[`SRC_FIFO_SERVICE] = state.service;
    status[`SRC_FIFO_ERROR] = fifo_error_flag;
    status[`SRC_LAST_WORD] = state.last_word;
    status[`SRC_STATS_READY] = stats_ready_source;
    status[`SRC_CCIR_ERROR] = ccir_error_flag;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;

    // raised by the core, dropped once the word is read
    if (last_word_ready) begin
      next_state.last_word = 1'b1;
    end else if (last_word_taken) begin
      next_state.last_word = 1'b0;
    end

    // fifo held empty while soft reset bit clear
    if (!state.mode[`MODE_SOFT_RUN]) begin
      next_state.service = state.mode[`MODE_DECODE];
    end else if (state.mode[`MODE_DECODE]) begin
      next_state.service = fifo_nearly_empty;
    end else begin
      next_state.service = fifo_nearly_full;
    end

    // zero-wait slave: ready in the first access cycle
    next_state.pready = setup;

    if (setup) begin
      next_state.pslverr = !(hit_mode || hit_mask || hit_status);
      next_state.prdata = '0;
      next_state.shown = '0;
      if (!pwrite) begin
        if (hit_mode) begin
          next_state.prdata[`MODE_W-1:0] = state.mode;
        end else if (hit_mask) begin
          next_state.prdata[`SRC_W-1:0] = state.mask;
        end else if (hit_status) begin
          next_state.prdata[`SRC_W-1:0] = status;
          next_state.shown = status;
        end
      end
    end

    // writes to status or unmapped addresses are ignored
    if (done && pwrite) begin
      if (hit_mode) begin
        next_state.mode = pwdata[`MODE_W-1:0];
      end else if (hit_mask) begin
        next_state.mask = pwdata[`SRC_W-1:0];
      end
    end

    if (done) begin
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state.mode <= `MODE_RESET;
      state.mask <= `MASK_RESET;
      state.shown <= '0;
      state.prdata <= '0;
      state.pready <= 1'b0;
      state.pslverr <= 1'b0;
      state.last_word <= 1'b0;
      state.service <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // interrupt line
  // ****************************************************************
  // masked, polarity-selected line
  irq_gate u_irq_gate (
    .clk(clk),
    .reset_n(reset_n),
    .status(status),
    .mask(state.mask),
    .active_high(state.mode[`MODE_IRQ_HIGH]),
    .irq(host_irq_out)
  );

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  // pin follows the sticky flag
  assign stats_ready_out = stats_ready_source;
  assign last_word_flag = state.last_word;
  assign fifo_service_request = state.service;
  assign decode_mode = state.mode[`MODE_DECODE];
  assign soft_reset_bit = state.mode[`MODE_SOFT_RUN];
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;

endmodule : codec_host_interrupt_status

`default_nettype wire

// *** codec_irq_props.sv ***
/*
  Concurrent checks on the host interrupt and status block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "codec_irq_defines.svh"
module codec_irq_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic stats_refreshed,
  input wire logic last_word_ready,
  input wire logic last_word_taken,
  input wire logic fifo_nearly_full,
  input wire logic fifo_nearly_empty,
  input wire logic stats_ready_out,
  input wire logic last_word_flag,
  input wire logic fifo_service_request,
  input wire logic host_irq_out,
  input wire logic decode_mode,
  input wire logic soft_reset_bit
);
  // ********
  // shadow of mask and polarity, taken from committed writes
  // ********
  logic [5:0] m;
  logic pol;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      m <= `MASK_RESET;
      pol <= 1'b1;
    end else if (wr && paddr == `OFF_MASK) begin
      m <= pwdata[5:0];
    end else if (wr && paddr == `OFF_MODE) begin
      pol <= pwdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_stats_rise: assert property (stats_refreshed |=> stats_ready_out)
    else $error("stats ready did not rise");
  chk_stats_hold: assert property (stats_ready_out && !(psel && penable && !pwrite && paddr == `OFF_STATUS)
    |=> stats_ready_out) else $error("stats ready dropped without a read");
  chk_stats_low: assert property (!stats_ready_out && !stats_refreshed |=> !stats_ready_out)
    else $error("stats ready rose without cause");
  chk_last_set: assert property (last_word_ready |=> last_word_flag)
    else $error("last word flag did not rise");
  chk_last_clear: assert property (last_word_taken && !last_word_ready |=> !last_word_flag)
    else $error("last word flag did not clear");
  chk_service_level: assert property ($past(reset_n) |-> fifo_service_request ==
    ($past(soft_reset_bit) ? ($past(decode_mode) ? $past(fifo_nearly_empty) : $past(fifo_nearly_full))
    : $past(decode_mode))) else $error("service request level wrong");
  chk_irq_active: assert property ($past(reset_n) && $past((stats_ready_out && m[4]) ||
    (last_word_flag && m[3])) |-> host_irq_out == $past(pol)) else $error("interrupt not active");
  chk_irq_idle: assert property ($past(reset_n) && $past(m) == 6'h00 |-> host_irq_out == !$past(pol))
    else $error("interrupt active with all sources masked");
  chk_reset_values: assert property (disable iff (1'b0) !reset_n |=> !stats_ready_out &&
    !last_word_flag && !host_irq_out && !decode_mode && !soft_reset_bit && !fifo_service_request)
    else $error("output not at reset value");
endmodule : codec_irq_props
bind codec_host_interrupt_status codec_irq_props i_props (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .stats_refreshed, .last_word_ready, .last_word_taken, .fifo_nearly_full,
  .fifo_nearly_empty, .stats_ready_out, .last_word_flag, .fifo_service_request, .host_irq_out,
  .decode_mode, .soft_reset_bit);
`default_nettype wire

// *** host_model.sv ***
/*
  Host processor model: apb master and chip reset driver.
  Assumes the bench supplies the clock and calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic reset_n,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset
  // released address and data show the inverse, so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// *** test_codec_host_interrupt_status.sv ***
/*
  Self-checking bench of the host interrupt and status block.
  Assumes the checker is bound by its own file and the host model drives apb.
*/
`timescale 1ns/1ps
`default_nettype none
`include "codec_irq_defines.svh"
module test_codec_host_interrupt_status;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic stats_ready_out, last_word_flag, fifo_service_request, host_irq_out, decode_mode, soft_reset_bit, e;
  logic [5:0] ev, st, mk;
  logic [1:0] lv;
  logic [2:0] md;
  int num_errors, num_checks, cycles, seed;
  host_model i_host (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  codec_host_interrupt_status i_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .stats_refreshed(ev[0]), .last_word_ready(ev[1]), .last_word_taken(ev[2]),
    .fifo_stop_event(ev[3]), .fifo_error_event(ev[4]), .ccir_error_event(ev[5]),
    .fifo_nearly_full(lv[0]), .fifo_nearly_empty(lv[1]), .stats_ready_out, .last_word_flag,
    .fifo_service_request, .host_irq_out, .decode_mode, .soft_reset_bit);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, far above the fewer than one thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [5:0] status_now();
    logic svc;
    svc = md[2] ? (md[1] ? lv[1] : lv[0]) : md[1];
    return {st[5:2], svc, st[0]};
  endfunction : status_now
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    i_host.xfer(1'b0, a, $random(seed), r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0);
    if (a == `OFF_MODE) md = d[2:0];
    if (a == `OFF_MASK) mk = d[5:0];
  endtask : wr
  // read clears only the sticky bits it returned
  task automatic rd_status;
    logic [5:0] s;
    s = status_now();
    rd(`OFF_STATUS, {26'h0, s}, 1'b0);
    st = st & ~(s & 6'h35);
  endtask : rd_status
  task automatic regs;
    rd(`OFF_MODE, {29'h0, md}, 1'b0);
    rd(`OFF_MASK, {26'h0, mk}, 1'b0);
    rd_status;
    rd(8'h0c, 32'h0, 1'b1);
  endtask : regs
  task automatic fire(input logic [5:0] x, input logic [1:0] l);
    @(posedge clk);
    ev <= x;
    lv <= l;
    @(posedge clk);
    ev <= 6'h00;
    st = st | {x[5], x[0], 1'b0, x[4], 1'b0, x[3]};
    if (x[1]) st[3] = 1'b1;
    else if (x[2]) st[3] = 1'b0;
  endtask : fire
  task automatic pins;
    logic [5:0] s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    s = status_now();
    check({26'h0, stats_ready_out, last_word_flag, fifo_service_request,
      host_irq_out, decode_mode, soft_reset_bit},
      {26'h0, s[4], s[3], s[1], ((|(s & mk)) ? md[0] : ~md[0]), md[1], md[2]});
  endtask : pins
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    seed = 32'h13ed5248;
    ev = 6'h00;
    lv = 2'b00;
    st = 6'h00;
    mk = `MASK_RESET;
    md = `MODE_RESET;
    i_host.do_reset;
    regs;
    $display("reset values done");
    for (int m = 0; m < 8; m++) begin
      wr(`OFF_MODE, ($random(seed) & ~32'h7) | 32'(m));
      wr(`OFF_MASK, (m % 3 == 0) ? 32'h0 : $random(seed));
      regs;
      for (int i = 0; i < 12; i++) begin
        fire(6'($random(seed)), 2'($random(seed)));
        pins;
        if (i % 3 == 2) begin
          rd_status;
          pins;
        end
      end
      $display("mode %0d done", m);
    end
    fire(6'h3b, 2'b11);
    i_host.do_reset;
    st = 6'h00;
    mk = `MASK_RESET;
    md = `MODE_RESET;
    regs;
    pins;
    $display("second reset done");
    end_of_test;
  end
endmodule : test_codec_host_interrupt_status
`default_nettype wire
